/* File: core/nand_host_ctrl.sv */
/*
 * host sequencer for a byte-wide nand flash: turns user commands into
 * command, address and data strobes, collects read bytes into a fifo.
 * assumes the flash pins are wired straight to the ports, io bus resolved
 * outside from io_bus_oe_o, and a pull-up on the ready/busy line.
 */
// Behaviour
// - command byte latched on write strobe rise
// - address byte latched with address latch high
// - three address cycles: column, low row, high
// - bit 8 picked by 00h or 01h
// - third cycle bit 7 driven low
// - program: 80h, address, data, then 10h
// - erase: 60h, two row cycles, D0h
// - id, reset, status: single command; spare takes address cycles
// - only reset or status while busy
// - spare read needs spare deselect low
// - keep spare deselect low permanently
module nand_host_ctrl (
	input  wire logic        clk_i,          // 25 MHz clock
	input  wire logic        rst_n_i,        // synchronous reset, low
	input  wire logic        cmd_valid_i,    // user command valid
	input  wire logic [2:0]  cmd_op_i,       // operation select
	input  wire logic [23:0] cmd_addr_i,     // flash byte address
	input  wire logic [9:0]  cmd_len_i,      // bytes to move
	output logic             cmd_ready_o,    // command taken when high
	output logic             done_o,         // operation finished pulse
	input  wire logic [7:0]  wr_data_i,      // program data byte
	input  wire logic        wr_valid_i,     // program data valid
	output logic             wr_ready_o,     // program data taken
	output logic [7:0]       rd_data_o,      // read data byte
	output logic             rd_valid_o,     // read data valid
	input  wire logic        rd_ready_i,     // read data accepted
	output logic             command_latch_en_o, // command latch
	output logic             address_latch_en_o, // address latch
	output logic             chip_select_n_o,    // chip select, low
	output logic             write_strobe_n_o,   // write strobe, low
	output logic             read_strobe_n_o,    // read strobe, low
	output logic             write_protect_n_o,  // write protect, low
	output logic             spare_area_deselect_o, // spare deselect
	output logic [7:0]       io_bus_o,       // io bus drive value
	output logic             io_bus_oe_o,    // io bus drive enable
	input  wire logic [7:0]  io_bus_i,       // io bus pin level
	input  wire logic        ready_busy_n_i  // ready/busy pin level
);
	typedef enum logic [2:0] {
		ST_IDLE, ST_CMD, ST_ADDR, ST_DATA, ST_CONFIRM, ST_SETTLE, ST_WAIT, ST_READ
	} state_t;

	state_t      state;
	logic [2:0]  ph, op;
	logic [23:0] addr;
	logic [9:0]  len, clamp_len;
	logic [1:0]  acnt;
	logic [7:0]  data_byte, wcnt, io_meta, io_sync, push_data;
	logic [7:0]  cmd_code, addr_byte, cur_byte;
	logic        rb_meta, rb_sync, push_valid, fifo_in_ready, was_idle;
	logic        take_cmd, take_wr, cap, write_st, page_read;
	logic        direct_read, has_addr, prog_erase;

	// pin inputs pass two flip-flops
	always_ff @(posedge clk_i)
	begin
		if (!rst_n_i)
		begin
			rb_meta <= 1'b0;
			rb_sync <= 1'b0;
			io_meta <= 8'h00;
			io_sync <= 8'h00;
		end
		else
		begin
			rb_meta <= ready_busy_n_i;
			rb_sync <= rb_meta;
			io_meta <= io_bus_i;
			io_sync <= io_meta;
		end
	end

	// decode of the current operation
	always_comb
	begin
		take_cmd    = cmd_valid_i & cmd_ready_o;
		take_wr     = wr_valid_i & wr_ready_o;
		cap         = (state == ST_READ) && (ph == nand_host_pkg::RD_LO_CYC) && !push_valid;
		write_st    = (state == ST_CMD) || (state == ST_ADDR) ||
		              (state == ST_DATA) || (state == ST_CONFIRM);
		page_read   = (op == nand_host_pkg::OP_READ_A) || (op == nand_host_pkg::OP_READ_B) ||
		              (op == nand_host_pkg::OP_READ_SPARE);
		direct_read = (op == nand_host_pkg::OP_READ_ID) || (op == nand_host_pkg::OP_STATUS);
		prog_erase  = (op == nand_host_pkg::OP_PROG) || (op == nand_host_pkg::OP_ERASE);
		has_addr    = page_read || prog_erase;
		clamp_len   = (cmd_len_i > nand_host_pkg::PAGE_BYTES) ?
		              nand_host_pkg::PAGE_BYTES : cmd_len_i;
		// command byte per operation
		unique case (op)
			nand_host_pkg::OP_READ_A:     cmd_code = nand_host_pkg::CMD_READ_A;
			nand_host_pkg::OP_READ_B:     cmd_code = nand_host_pkg::CMD_READ_B;
			nand_host_pkg::OP_READ_SPARE: cmd_code = nand_host_pkg::CMD_READ_SPARE;
			nand_host_pkg::OP_READ_ID:    cmd_code = nand_host_pkg::CMD_READ_ID;
			nand_host_pkg::OP_STATUS:     cmd_code = nand_host_pkg::CMD_STATUS;
			nand_host_pkg::OP_PROG:       cmd_code = nand_host_pkg::CMD_PROG;
			nand_host_pkg::OP_ERASE:      cmd_code = nand_host_pkg::CMD_ERASE;
			nand_host_pkg::OP_RESET:      cmd_code = nand_host_pkg::CMD_RESET;
		endcase
		// address byte in column, low row, high row order; bit 8 never sent
		unique case (acnt)
			2'h0:    addr_byte = addr[7:0];
			2'h1:    addr_byte = addr[16:9];
			default: addr_byte = {1'b0, addr[23:17]};
		endcase
		// byte driven on the io bus for each write state
		unique case (state)
			ST_CMD:     cur_byte = cmd_code;
			ST_ADDR:    cur_byte = addr_byte;
			ST_DATA:    cur_byte = data_byte;
			ST_CONFIRM: cur_byte = (op == nand_host_pkg::OP_PROG) ?
			                       nand_host_pkg::CMD_PROG_GO : nand_host_pkg::CMD_ERASE_GO;
			default:    cur_byte = 8'h00;
		endcase
	end

	// operation sequencer
	always_ff @(posedge clk_i)
	begin
		if (!rst_n_i)
		begin
			state     <= ST_IDLE;
			ph        <= 3'h0;
			op        <= 3'h0;
			addr      <= 24'h000000;
			len       <= 10'h000;
			acnt      <= 2'h0;
			data_byte <= 8'h00;
			wcnt      <= 8'h00;
		end
		else
		begin
			unique case (state)
				ST_IDLE:
					if (take_cmd)
					begin
						op    <= cmd_op_i;
						addr  <= cmd_addr_i;
						len   <= clamp_len;
						acnt  <= (cmd_op_i == nand_host_pkg::OP_ERASE) ?
						         nand_host_pkg::ADDR_ROW : 2'h0;
						ph    <= 3'h0;
						wcnt  <= 8'h00; // settle count starts fresh for every op
						state <= ST_CMD;
					end
				ST_CMD:
					if (ph == nand_host_pkg::PH_LATCH)
					begin
						ph <= 3'h0;
						if (has_addr)
							state <= ST_ADDR;
						else if (op == nand_host_pkg::OP_RESET)
							state <= ST_SETTLE;
						else if (direct_read && len != 10'h000)
							state <= ST_READ;
						else
							state <= ST_IDLE;
					end
					else
						ph <= ph + 3'h1;
				ST_ADDR:
					if (ph == nand_host_pkg::PH_LATCH)
					begin
						ph <= 3'h0;
						if (acnt == nand_host_pkg::ADDR_LAST)
						begin
							if (op == nand_host_pkg::OP_ERASE)
								state <= ST_CONFIRM;
							else if (op == nand_host_pkg::OP_PROG)
								state <= (len != 10'h000) ? ST_DATA : ST_CONFIRM;
							else
								state <= ST_SETTLE;
						end
						else
							acnt <= acnt + 2'h1;
					end
					else
						ph <= ph + 3'h1;
				ST_DATA:
					if (ph == nand_host_pkg::PH_SETUP)
					begin
						if (take_wr)
						begin
							data_byte <= wr_data_i;
							ph        <= nand_host_pkg::PH_STROBE;
						end
					end
					else if (ph == nand_host_pkg::PH_LATCH)
					begin
						ph  <= 3'h0;
						len <= len - 10'h001;
						if (len == 10'h001)
							state <= ST_CONFIRM;
					end
					else
						ph <= ph + 3'h1;
				ST_CONFIRM:
					if (ph == nand_host_pkg::PH_LATCH)
					begin
						ph    <= 3'h0;
						wcnt  <= 8'h00;
						state <= ST_SETTLE;
					end
					else
						ph <= ph + 3'h1;
				ST_SETTLE:
					if (wcnt == nand_host_pkg::SETTLE_CYC)
					begin
						wcnt  <= 8'h00;
						state <= ST_WAIT;
					end
					else
						wcnt <= wcnt + 8'h01;
				ST_WAIT:
				begin
					wcnt <= wcnt + 8'h01;
					// reset gives up after its longest busy time
					if (rb_sync || (op == nand_host_pkg::OP_RESET &&
					    wcnt == nand_host_pkg::RST_CYC))
					begin
						ph    <= 3'h0;
						state <= (page_read && len != 10'h000) ? ST_READ : ST_IDLE;
					end
				end
				ST_READ:
					if (ph == nand_host_pkg::RD_LO_CYC + 3'h1)
					begin
						ph  <= 3'h0;
						len <= len - 10'h001;
						if (len == 10'h001)
							state <= ST_IDLE;
					end
					else if (ph != nand_host_pkg::RD_LO_CYC || cap)
						ph <= ph + 3'h1;
			endcase
		end
	end

	// read byte handed to the fifo; holds the strobe while the fifo is full
	always_ff @(posedge clk_i)
	begin
		if (!rst_n_i)
		begin
			push_valid <= 1'b0;
			push_data  <= 8'h00;
		end
		else if (cap)
		begin
			push_valid <= 1'b1;
			push_data  <= io_sync;
		end
		else if (fifo_in_ready)
			push_valid <= 1'b0;
	end

	// user handshakes
	always_ff @(posedge clk_i)
	begin
		if (!rst_n_i)
		begin
			cmd_ready_o <= 1'b0;
			wr_ready_o  <= 1'b0;
			done_o      <= 1'b0;
			was_idle    <= 1'b1;
		end
		else
		begin
			cmd_ready_o <= (state == ST_IDLE) && rb_sync && !take_cmd;
			wr_ready_o  <= (state == ST_DATA) && (ph == nand_host_pkg::PH_SETUP) && !take_wr;
			was_idle    <= (state == ST_IDLE);
			done_o      <= (state == ST_IDLE) && !was_idle;
		end
	end

	// flash pins, all registered
	always_ff @(posedge clk_i)
	begin
		if (!rst_n_i)
		begin
			command_latch_en_o    <= 1'b0;
			address_latch_en_o    <= 1'b0;
			chip_select_n_o       <= 1'b1;
			write_strobe_n_o      <= 1'b1;
			read_strobe_n_o       <= 1'b1;
			write_protect_n_o     <= 1'b0;
			spare_area_deselect_o <= 1'b0;
			io_bus_o              <= 8'h00;
			io_bus_oe_o           <= 1'b0;
		end
		else
		begin
			command_latch_en_o    <= (state == ST_CMD) || (state == ST_CONFIRM);
			address_latch_en_o    <= (state == ST_ADDR);
			chip_select_n_o       <= (state == ST_IDLE);
			write_strobe_n_o      <= !(write_st && ph == nand_host_pkg::PH_STROBE);
			read_strobe_n_o       <= !(state == ST_READ && ph <= nand_host_pkg::RD_LO_CYC);
			write_protect_n_o     <= prog_erase && (state != ST_IDLE);
			spare_area_deselect_o <= 1'b0;
			io_bus_o              <= cur_byte;
			io_bus_oe_o           <= write_st;
		end
	end

	// read data buffer
	byte_fifo #(
		.WIDTH (nand_host_pkg::FIFO_W),
		.DEPTH (nand_host_pkg::FIFO_D)
	) u_rd_fifo (
		.clk_i       (clk_i),
		.rst_n_i     (rst_n_i),
		.in_valid_i  (push_valid),
		.in_data_i   (push_data),
		.in_ready_o  (fifo_in_ready),
		.out_valid_o (rd_valid_o),
		.out_data_o  (rd_data_o),
		.out_ready_i (rd_ready_i)
	);

endmodule : nand_host_ctrl

/* File: core/nand_host_pkg.sv */
/*
 * constants for the nand flash host sequencer: command codes, operation
 * selects, page geometry and pin timing counts.
 * assumes a 25 MHz system clock.
 */
package nand_host_pkg;

	// command bytes written with the command latch high
	localparam logic [7:0] CMD_READ_A     = 8'h00;
	localparam logic [7:0] CMD_READ_B     = 8'h01;
	localparam logic [7:0] CMD_READ_SPARE = 8'h50;
	localparam logic [7:0] CMD_READ_ID    = 8'h90;
	localparam logic [7:0] CMD_RESET      = 8'hFF;
	localparam logic [7:0] CMD_PROG       = 8'h80;
	localparam logic [7:0] CMD_PROG_GO    = 8'h10;
	localparam logic [7:0] CMD_ERASE      = 8'h60;
	localparam logic [7:0] CMD_ERASE_GO   = 8'hD0;
	localparam logic [7:0] CMD_STATUS     = 8'h70;

	// operation selects on the user command port
	localparam logic [2:0] OP_READ_A     = 3'h0;
	localparam logic [2:0] OP_READ_B     = 3'h1;
	localparam logic [2:0] OP_READ_SPARE = 3'h2;
	localparam logic [2:0] OP_READ_ID    = 3'h3;
	localparam logic [2:0] OP_STATUS     = 3'h4;
	localparam logic [2:0] OP_PROG       = 3'h5;
	localparam logic [2:0] OP_ERASE      = 3'h6;
	localparam logic [2:0] OP_RESET      = 3'h7;

	// geometry
	localparam int         ADDR_W     = 24;
	localparam int         LEN_W      = 10;
	localparam logic [9:0] PAGE_BYTES = 10'h210;	// 528 bytes per page
	localparam logic [1:0] ADDR_LAST  = 2'h2;	// third address cycle
	localparam logic [1:0] ADDR_ROW   = 2'h1;	// first row address cycle
	localparam int         FIFO_W     = 8;
	localparam int         FIFO_D     = 16;

	// timing
	localparam int         CLK_NS      = 40;
	localparam int         T_SETTLE_NS = 200;	// wait before sampling busy
	localparam int         T_RST_NS    = 5000;	// longest reset busy
	localparam int         T_RC_NS     = 50;	// least serial read cycle
	localparam logic [7:0] SETTLE_CYC  = 8'((T_SETTLE_NS + CLK_NS - 1) / CLK_NS);
	localparam logic [7:0] RST_CYC     = 8'(T_RST_NS / CLK_NS);
	localparam logic [2:0] RC_CYC      = 3'((T_RC_NS + CLK_NS - 1) / CLK_NS);
	localparam logic [2:0] RD_LO_CYC   = 3'h5;	// covers pin lag and sync
	localparam logic [2:0] PH_SETUP    = 3'h0;
	localparam logic [2:0] PH_STROBE   = 3'h1;
	localparam logic [2:0] PH_LATCH    = 3'h2;

endpackage : nand_host_pkg

/* File: core/byte_fifo.sv */
/*
 * first-word-fall-through fifo with a registered output stage and a
 * registered input ready.
 * assumes depth is a power of two, at least two.
 */
module byte_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 16
) (
	input  wire logic             clk_i,       // system clock
	input  wire logic             rst_n_i,     // synchronous reset, low
	input  wire logic             in_valid_i,  // write side valid
	input  wire logic [WIDTH-1:0] in_data_i,   // write side data
	output logic                  in_ready_o,  // write side ready
	output logic                  out_valid_o, // read side valid
	output logic      [WIDTH-1:0] out_data_o,  // read side data
	input  wire logic             out_ready_i  // read side ready
);
	localparam int          AW   = $clog2(DEPTH);
	localparam logic [AW:0] FULL = (AW + 1)'(DEPTH);

	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0]    wr_ptr;
	logic [AW-1:0]    rd_ptr;
	logic [AW:0]      held;
	logic             push;
	logic             pop;
	logic             load;
	logic             take_mem;
	logic             bypass;
	logic             store;
	logic [AW:0]      next_held;
	logic             next_valid;

	// movement between input, storage and output register
	always_comb
	begin
		push       = in_valid_i & in_ready_o;
		pop        = out_valid_o & out_ready_i;
		load       = ~out_valid_o | pop;
		take_mem   = load & (held != '0);
		bypass     = load & (held == '0) & push;
		store      = push & ~bypass;
		next_held  = held + {{AW{1'b0}}, store} - {{AW{1'b0}}, take_mem};
		next_valid = load ? ((held != '0) | push) : 1'b1;
	end

	// storage array, no reset needed
	always_ff @(posedge clk_i)
	begin
		if (store)
			mem[wr_ptr] <= in_data_i;
	end

	// pointers, fill level and flags
	always_ff @(posedge clk_i)
	begin
		if (!rst_n_i)
		begin
			wr_ptr      <= '0;
			rd_ptr      <= '0;
			held        <= '0;
			out_valid_o <= 1'b0;
			in_ready_o  <= 1'b1;
		end
		else
		begin
			wr_ptr      <= wr_ptr + AW'(store);
			rd_ptr      <= rd_ptr + AW'(take_mem);
			held        <= next_held;
			out_valid_o <= next_valid;
			in_ready_o  <= (next_held + {{AW{1'b0}}, next_valid}) < FULL; // stall source
		end
	end

	// output data register
	always_ff @(posedge clk_i)
	begin
		if (!rst_n_i)
			out_data_o <= '0;
		else if (take_mem)
			out_data_o <= mem[rd_ptr];
		else if (bypass)
			out_data_o <= in_data_i;
	end

endmodule : byte_fifo

/* File: verification/nand_host_sva.sv */
/* assertions on the nand host controller pins and command port.
   bound below to every controller instance; one clock, sync reset. */
module nand_host_sva (
	input wire logic clk_i,                 // clock
	input wire logic rst_n_i,               // reset, low
	input wire logic cmd_valid_i,           // command valid
	input wire logic cmd_ready_o,           // command ready
	input wire logic done_o,                // done pulse
	input wire logic command_latch_en_o,    // command latch
	input wire logic address_latch_en_o,    // address latch
	input wire logic chip_select_n_o,       // select, low
	input wire logic write_strobe_n_o,      // write strobe
	input wire logic read_strobe_n_o,       // read strobe
	input wire logic write_protect_n_o,     // protect, low
	input wire logic spare_area_deselect_o, // spare deselect
	input wire logic io_bus_oe_o,           // io drive enable
	input wire logic ready_busy_n_i         // busy line
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge clk_i); endclocking
	default disable iff (!rst_n_i);

	// strobe, latch, select and handshake relations on the flash pins and command port
	a_latch_one: assert property (!(command_latch_en_o && address_latch_en_o))
		else $error("both latch enables high");
	a_strobe_sel: assert property (!write_strobe_n_o |-> !chip_select_n_o)
		else $error("write strobe without select");
	a_strobe_pulse: assert property ($fell(write_strobe_n_o) |=> write_strobe_n_o)
		else $error("write strobe low too long");
	a_cmd_driven: assert property (!write_strobe_n_o && command_latch_en_o |-> io_bus_oe_o)
		else $error("command byte not driven");
	a_read_width: assert property ($fell(read_strobe_n_o) |-> !read_strobe_n_o [*6])
		else $error("read strobe too short");
	a_read_float: assert property (!read_strobe_n_o |-> !io_bus_oe_o)
		else $error("host drives io during read");
	a_spare_low: assert property (!spare_area_deselect_o)
		else $error("spare deselect raised");
	a_idle_safe: assert property (cmd_ready_o |-> chip_select_n_o && !write_protect_n_o)
		else $error("idle with select or protect off");
	a_busy_block: assert property (!ready_busy_n_i [*5] |-> !cmd_ready_o)
		else $error("ready while flash busy");
	a_take_drop: assert property (cmd_valid_i && cmd_ready_o |=> !cmd_ready_o)
		else $error("ready stays after take");
	a_done_once: assert property (done_o |=> !done_o)
		else $error("done longer than a cycle");
endmodule : nand_host_sva

bind nand_host_ctrl nand_host_sva u_sva (.clk_i(clk_i), .rst_n_i(rst_n_i),
	.cmd_valid_i(cmd_valid_i), .cmd_ready_o(cmd_ready_o), .done_o(done_o),
	.command_latch_en_o(command_latch_en_o), .address_latch_en_o(address_latch_en_o),
	.chip_select_n_o(chip_select_n_o), .write_strobe_n_o(write_strobe_n_o),
	.read_strobe_n_o(read_strobe_n_o), .write_protect_n_o(write_protect_n_o),
	.spare_area_deselect_o(spare_area_deselect_o), .io_bus_oe_o(io_bus_oe_o),
	.ready_busy_n_i(ready_busy_n_i));

/* File: verification/nand_flash_model.sv */
/* behavioural nand flash on the far side of the host controller.
   pins come straight from the controller; the bench resolves io and busy. */
module nand_flash_model #(
	parameter int         BUSY_NS = 2000,  // fetch, program, erase busy
	parameter int         RST_NS  = 1000,  // reset busy
	parameter logic [7:0] ID_CODE = 8'h3C, // arbitrary identity value
	parameter logic [7:0] STAT_OK = 8'hC0  // status byte when ready
) (
	input  wire logic       cmd_latch_i,     // command latch
	input  wire logic       addr_latch_i,    // address latch
	input  wire logic       sel_n_i,         // select, low
	input  wire logic       wr_n_i,          // write strobe
	input  wire logic       read_strobe_n_i, // read strobe
	input  wire logic       prot_n_i,        // protect, low
	input  wire logic       spare_off_i,     // spare deselect
	input  wire logic [7:0] io_bus_i,        // io level
	output logic      [7:0] io_q_o,          // read byte
	output logic            io_oe_o,         // device drives io
	output logic            busy_o,          // pulls busy low
	output int              err_o            // host faults seen
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0] cmd = 8'h00, rlo = 8'h00, rhi = 8'h00;
	logic [1:0] acnt = 2'h0;
	int         base = 0, ptr = 0;
	logic [7:0] mem[int], preg[int];
	bit         ers[int];

	// idle state at start
	initial
	begin
		busy_o = 1'h0;
		err_o = 0;
		io_q_o = 8'h00;
	end

	function automatic int key(input int c);
		return int'({rhi[6:0], rlo}) * 528 + c;
	endfunction : key

	function automatic logic [7:0] byte_at(input int k);
		if (mem.exists(k)) return mem[k];
		if (ers.exists(k / 16896)) return 8'hFF;
		return 8'(k ^ (k >> 7));
	endfunction : byte_at

	task automatic go_busy(input int ns);
		busy_o = 1'h1;
		fork
			#(ns * 1ns) busy_o = 1'h0;
		join_none
	endtask : go_busy

	// io floats unless selected and read strobe low
	assign io_oe_o = !sel_n_i && !read_strobe_n_i;

	// command, address and data latched on the write strobe rise
	always @(posedge wr_n_i)
	begin
		if (!sel_n_i && cmd_latch_i)
		begin
			if (busy_o && io_bus_i != 8'hFF && io_bus_i != 8'h70) err_o++;
			if (base == 256) base = 0;
			cmd = io_bus_i;
			acnt = (io_bus_i == 8'h60) ? 2'h1 : 2'h0;
			if (io_bus_i == 8'h00 || io_bus_i == 8'hFF) base = 0;
			if (io_bus_i == 8'h01) base = 256;
			if (io_bus_i == 8'h50) base = 512;
			if (io_bus_i == 8'h50 && spare_off_i) err_o++;
			if (io_bus_i == 8'hFF) go_busy(RST_NS);
			if (io_bus_i == 8'h10 && prot_n_i) foreach (preg[k]) mem[key(k)] = preg[k];
			if (io_bus_i == 8'hD0 && prot_n_i) ers[key(0) / 16896] = 1'b1;
			if (io_bus_i == 8'hD0 && prot_n_i)
				for (int k = 0; k < 16896; k++) mem.delete(key(0) / 16896 * 16896 + k);
			if ((io_bus_i == 8'h10 || io_bus_i == 8'hD0) && !prot_n_i) err_o++;
			if (io_bus_i == 8'h10 || io_bus_i == 8'hD0) go_busy(BUSY_NS);
			if (io_bus_i == 8'h10) preg.delete();
		end
		else if (!sel_n_i && addr_latch_i)
		begin
			if (acnt == 2'h0) ptr = base + ((base == 512) ? int'(io_bus_i[3:0]) : int'(io_bus_i));
			if (acnt == 2'h1) rlo = io_bus_i;
			if (acnt == 2'h2) rhi = io_bus_i;
			if (acnt == 2'h2 && io_bus_i[7]) err_o++;
			if (acnt == 2'h2 && (cmd == 8'h00 || cmd == 8'h01 || cmd == 8'h50)) go_busy(BUSY_NS);
			acnt++;
		end
		else if (!sel_n_i)
		begin
			preg[ptr] = io_bus_i;
			ptr++;
		end
	end

	// deselect during a page fetch would drop the read back to standby
	always @(posedge sel_n_i)
		if (busy_o && (cmd == 8'h00 || cmd == 8'h01 || cmd == 8'h50)) err_o++;

	// next byte out on each read strobe fall
	always @(negedge read_strobe_n_i)
	begin
		if (!sel_n_i && busy_o) err_o++;
		if (!sel_n_i) io_q_o = (cmd == 8'h90) ? ID_CODE : (cmd == 8'h70) ? STAT_OK : byte_at(key(ptr));
		if (!sel_n_i) ptr++;
	end
endmodule : nand_flash_model

/* File: verification/nand_flash_command_interface_bench.sv */
/* self-checking bench: host controller against a behavioural flash.
   assumes package, fifo, controller, checker and model compiled first. */
module nand_flash_command_interface_bench;
	timeunit 1ns;
	timeprecision 1ps;
	localparam logic [7:0] ID_CODE = 8'h5A; // arbitrary identity value
	localparam logic [7:0] STAT_OK = 8'hC0;
	logic        clk_i = 1'h0, rst_n_i = 1'h0, cmd_valid_i = 1'h0, wr_valid_i = 1'h0;
	logic        rd_ready_i = 1'h0, stall = 1'h0;
	logic [2:0]  cmd_op_i = 3'h0;
	logic [23:0] cmd_addr_i = 24'h0, a;
	logic [9:0]  cmd_len_i = 10'h0;
	logic [7:0]  wr_data_i = 8'h00, rd_data_o, io_bus_o, io_q, io_bus_i;
	logic        cmd_ready_o, done_o, wr_ready_o, rd_valid_o, cl_en, al_en, sel_n, wr_n;
	logic        rs_n, prot_n, spare_off, io_bus_oe_o, io_oe, busy, ready_busy_n_i;
	int          bad_count = 0, checked = 0, seed, took, err;
	logic [7:0]  rq[$], wq[$], bmem[int];
	bit          bers[int];

	// wire levels: host, else flash, else inverse of last; pull-up on busy
	assign io_bus_i = io_bus_oe_o ? io_bus_o : io_oe ? io_q : ~io_q;
	assign ready_busy_n_i = !busy;

	initial forever #20 clk_i = ~clk_i;

	nand_host_ctrl u_dut (.clk_i(clk_i), .rst_n_i(rst_n_i), .cmd_valid_i(cmd_valid_i),
		.cmd_op_i(cmd_op_i), .cmd_addr_i(cmd_addr_i), .cmd_len_i(cmd_len_i),
		.cmd_ready_o(cmd_ready_o), .done_o(done_o), .wr_data_i(wr_data_i),
		.wr_valid_i(wr_valid_i), .wr_ready_o(wr_ready_o), .rd_data_o(rd_data_o),
		.rd_valid_o(rd_valid_o), .rd_ready_i(rd_ready_i), .command_latch_en_o(cl_en),
		.address_latch_en_o(al_en), .chip_select_n_o(sel_n), .write_strobe_n_o(wr_n),
		.read_strobe_n_o(rs_n), .write_protect_n_o(prot_n), .spare_area_deselect_o(spare_off),
		.io_bus_o(io_bus_o), .io_bus_oe_o(io_bus_oe_o), .io_bus_i(io_bus_i),
		.ready_busy_n_i(ready_busy_n_i));

	nand_flash_model #(.ID_CODE(ID_CODE), .STAT_OK(STAT_OK)) u_mem (.cmd_latch_i(cl_en),
		.addr_latch_i(al_en), .sel_n_i(sel_n), .wr_n_i(wr_n), .read_strobe_n_i(rs_n),
		.prot_n_i(prot_n), .spare_off_i(spare_off), .io_bus_i(io_bus_i), .io_q_o(io_q),
		.io_oe_o(io_oe), .busy_o(busy), .err_o(err));

	// collect read bytes, feed program bytes, random read back-pressure
	always @(posedge clk_i)
	begin
		if (rd_valid_o && rd_ready_i) rq.push_back(rd_data_o);
		if (wr_valid_i && wr_ready_o) void'(wq.pop_front());
		wr_valid_i <= wq.size() != 0;
		wr_data_i <= (wq.size() != 0) ? wq[0] : 8'h00;
		rd_ready_i <= !stall && ($random(seed) % 4 != 0);
	end

	function automatic logic [7:0] exp_byte(input int k);
		if (bmem.exists(k)) return bmem[k];
		if (bers.exists(k / 16896)) return 8'hFF;
		return 8'(k ^ (k >> 7));
	endfunction : exp_byte

	task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
		checked++;
		if (got !== exp) bad_count++;
		if (got !== exp) $display("mismatch %s expected %h seen %h", what, exp, got);
	endtask : check

	task automatic run(input logic [2:0] op, input logic [23:0] ad, input logic [9:0] n);
		int w;
		int c;
		c = (op == 3'h1) ? 256 + ad[7:0] : (op == 3'h2) ? 512 + ad[3:0] : int'(ad[7:0]);
		rq.delete();
		cmd_op_i <= op;
		cmd_addr_i <= ad;
		cmd_len_i <= n;
		cmd_valid_i <= 1'h1;
		w = 0;
		do @(posedge clk_i); while (cmd_ready_o !== 1'h1 && w++ < 9000);
		cmd_valid_i <= 1'h0;
		took = 0;
		do @(posedge clk_i); while (done_o !== 1'h1 && took++ < 9000);
		check("op finished", 32'h1, 32'(took < 9000));
		w = 0;
		while (op < 3'h5 && rq.size() < n && w++ < 900) @(posedge clk_i);
		for (int i = 0; i < n && op < 3'h3; i++)
			check("read byte", exp_byte(int'(ad[23:9]) * 528 + c + i), rq[i]);
		$display("op %0d done after %0d cycles", op, took);
	endtask : run

	task automatic print_verdict();
		$display("checked %0d bad_count %0d", checked, bad_count);
		if (bad_count == 0 && checked > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : print_verdict

	// main sequence: reset, status, id, erase and program, corners, random, stall
	initial
	begin
		seed = 32'h9CD493F8;
		repeat (5) @(posedge clk_i);
		rst_n_i <= 1'h1;
		run(nand_host_pkg::OP_RESET, 24'h0, 10'h0);
		check("reset busy bound", 32'h1, 32'(took < 200));
		run(nand_host_pkg::OP_STATUS, 24'h0, 10'h1);
		check("status byte", 32'(STAT_OK), 32'(rq[0]));
		run(nand_host_pkg::OP_READ_ID, 24'h0, 10'h1);
		check("id byte", 32'(ID_CODE), 32'(rq[0]));
		a = (24'($random(seed)) & 24'hFFC000) | 24'h000020;
		run(nand_host_pkg::OP_ERASE, a, 10'h0);
		bers[int'(a[23:14])] = 1'b1;
		for (int i = 0; i < 5; i++) wq.push_back(8'($random(seed)));
		for (int i = 0; i < 5; i++) bmem[int'(a[23:9]) * 528 + 32 + i] = wq[i];
		run(nand_host_pkg::OP_PROG, a, 10'h5);
		run(nand_host_pkg::OP_READ_A, a, 10'h8);
		run(nand_host_pkg::OP_READ_A, a + 24'h1E0, 10'h4);
		run(nand_host_pkg::OP_READ_B, 24'h3451FF, 10'h8);
		run(nand_host_pkg::OP_READ_SPARE, 24'h012308, 10'h8);
		repeat (6) run(3'($unsigned($random(seed)) % 3), 24'($random(seed)) & 24'hFFFFF7,
			10'(1 + $unsigned($random(seed)) % 8));
		stall = 1'h1;
		fork
		begin
			repeat (300) @(posedge clk_i);
			check("strobe held on full fifo", 32'h0, 32'(rs_n));
			check("valid held", 32'h1, 32'(rd_valid_o));
			check("bytes while stalled", 32'h0, 32'(rq.size()));
			stall = 1'h0;
		end
		join_none
		run(nand_host_pkg::OP_READ_A, 24'h0A5200, 10'h28);
		check("flash side faults", 32'h0, 32'(err));
		print_verdict();
	end

	// hang guard
	initial
	begin
		repeat (40000) @(posedge clk_i);
		bad_count++;
		print_verdict();
	end
endmodule : nand_flash_command_interface_bench
